// file: dv/bmrs_fabric_model.sv
`timescale 1ns/100ps
module bmrs_fabric_model (
    input wire logic clk,
    output logic     fullReq,
    output logic     rpReq,
    output logic     gsrReq,
    output logic     ce,
    output logic     we,
    output logic     re
);
    // Enables stay high; the sequencer owns the quiet windows
    initial begin
        {fullReq, rpReq, gsrReq} = 3'h0;
        {ce, we, re} = 3'h7;
    end
    // Changes only just after an edge of a steady clock
    task automatic setReq(input logic [2:0] sel);
        @(posedge clk);
        #1 {fullReq, rpReq, gsrReq} = sel;
    endtask : setReq
endmodule : bmrs_fabric_model

// file: dv/bmrs_sequencer_props.sv
`timescale 1ns/100ps
module bmrs_sequencer_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic fifoMode,
    input wire logic gsrEnable,
    input wire logic fullResetReq,
    input wire logic globalSetResetReq,
    input wire logic memWriteEnable,
    input wire logic memReadPortEnable,
    input wire logic memFullReset,
    input wire logic memReadPointerReset,
    input wire logic globalSetReset,
    input wire logic busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_quiet; memFullReset |-> !memWriteEnable && !memReadPortEnable; endproperty
    a_quiet: assert property (p_quiet) else $error("enable live in reset");
    property p_rpQuiet; memReadPointerReset |-> !memReadPortEnable; endproperty
    a_rpQuiet: assert property (p_rpQuiet) else $error("read enable live");
    property p_pre; $rose(memFullReset) |-> $past(!memWriteEnable && !memReadPortEnable); endproperty
    a_pre: assert property (p_pre) else $error("no quiet before reset");
    property p_post; $fell(memFullReset) |-> !memWriteEnable && !memReadPortEnable; endproperty
    a_post: assert property (p_post) else $error("no quiet after reset");
    property p_fifoGsr;
        $rose(busy) && fifoMode && globalSetResetReq ##1 globalSetResetReq[*3] |=> globalSetReset;
    endproperty
    a_fifoGsr: assert property (p_fifoGsr) else $error("fifo gsr missing");
    property p_full; $rose(busy) && fullResetReq ##1 fullResetReq[*3] |=> memFullReset; endproperty
    a_full: assert property (p_full) else $error("full reset late");
    property p_refuse; !gsrEnable && !fifoMode |-> !globalSetReset; endproperty
    a_refuse: assert property (p_refuse) else $error("gsr not refused");
    property p_drop; $fell(fullResetReq) && memFullReset |=> !memFullReset; endproperty
    a_drop: assert property (p_drop) else $error("full reset stuck");
    c_full: cover property ($rose(memFullReset));
    c_rp: cover property ($rose(memReadPointerReset));
    c_gsr: cover property ($rose(globalSetReset));
endmodule : bmrs_sequencer_props
bind bmrs_sequencer bmrs_sequencer_props u_props (.*);

// file: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
    import bmrs_pkg::*;
    logic clk, resetn, fifoMode, gsrEnable, fq, rq, gq, ce, we, re;
    logic mCe, mWe, mRe, fr, rr, gr, busy;
    int   miscompares = 0;
    int   samples_checked = 0;
    bmrs_fabric_model m (.clk(clk), .fullReq(fq), .rpReq(rq), .gsrReq(gq), .ce(ce), .we(we), .re(re));
    bmrs_sequencer dut (.clk(clk), .resetn(resetn), .fifoMode(fifoMode), .gsrEnable(gsrEnable),
        .fullResetReq(fq), .readPointerResetReq(rq), .globalSetResetReq(gq),
        .userClockEnable(ce), .userWriteEnable(we), .userReadPortEnable(re),
        .memClockEnable(mCe), .memWriteEnable(mWe), .memReadPortEnable(mRe), .memFullReset(fr),
        .memReadPointerReset(rr), .globalSetReset(gr), .busy(busy));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task final_report;
        $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic runReq(input logic [2:0] sel, input logic fm, ge, input logic [2:0] exp);
        @(posedge clk);
        #1 {fifoMode, gsrEnable} = {fm, ge};
        m.setReq(sel);
        @(posedge clk);
        #1 check(busy, |exp);
        repeat (3) @(posedge clk);
        #1 check({fr, rr, gr}, exp);
        check({mWe, mRe}, {~(exp[2] | exp[0]), exp == 3'h0});
        check(mCe, exp == 3'h0);
        m.setReq(3'h0);
        repeat (2) @(posedge clk);
        #1 check({fr, rr, gr, mRe}, {3'h0, exp == 3'h0});
        @(posedge clk);
        #1 check(mRe, 1'b1);
        $display("test done sel=%h mode=%h", sel, fm);
    endtask : runReq
    task automatic t_fifoFull; runReq(3'h4, 1'b1, 1'b0, 3'h4); endtask : t_fifoFull
    task automatic t_fifoRp; runReq(3'h2, 1'b1, 1'b0, 3'h2); endtask : t_fifoRp
    task automatic t_fifoGsr; runReq(3'h1, 1'b1, 1'b0, 3'h1); endtask : t_fifoGsr
    task automatic t_ramGsr; runReq(3'h1, 1'b0, 1'b1, 3'h1); endtask : t_ramGsr
    task automatic t_gsrOff; runReq(3'h1, 1'b0, 1'b0, 3'h0); endtask : t_gsrOff
    initial begin
        #2000;
        miscompares++;
        final_report();
    end
    initial begin
        {resetn, fifoMode, gsrEnable} = 3'h0;
        repeat (20) @(posedge clk);
        #1 resetn = 1'b1;
        t_fifoFull();
        t_fifoRp();
        t_fifoGsr();
        t_ramGsr();
        t_gsrOff();
        final_report();
    end
endmodule : testbench

// file: hw/bmrs_defines.svh
`ifndef BMRS_DEFINES_SVH
`define BMRS_DEFINES_SVH
`define BMRS_QUIET_CYCLES   4'h1
`define BMRS_SETTLE_CYCLES  4'h1
`endif

// file: hw/bmrs_pkg.sv
package bmrs_pkg;
    typedef enum logic [2:0] {
        BMRS_RUN,
        BMRS_PRE_QUIET,
        BMRS_IN_RESET,
        BMRS_POST_QUIET
    } bmrs_state_t;
endpackage : bmrs_pkg

// file: hw/bmrs_quiet_counter.sv
`timescale 1ns/100ps
// Counts cycles of a condition, flags when count reached
module bmrs_quiet_counter #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             clear,
    input  wire logic [WIDTH-1:0] target,
    output logic                  done
);
    logic [WIDTH-1:0] count_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= '0;
        end else if (clear) begin
            count_q <= '0;
        end else if (count_q != target) begin
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign done = !clear && (count_q == target);
endmodule : bmrs_quiet_counter

// file: hw/bmrs_sequencer.sv
`timescale 1ns/100ps
`include "bmrs_defines.svh"
// ----------------------------------------------------------------
// Reset sequencer for embedded block memory
// ----------------------------------------------------------------
module bmrs_sequencer #(
    parameter int unsigned CNT_W = 4
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             fifoMode,
    input  wire logic             gsrEnable,
    input  wire logic             fullResetReq,
    input  wire logic             readPointerResetReq,
    input  wire logic             globalSetResetReq,
    input  wire logic             userClockEnable,
    input  wire logic             userWriteEnable,
    input  wire logic             userReadPortEnable,
    output logic                  memClockEnable,
    output logic                  memWriteEnable,
    output logic                  memReadPortEnable,
    output logic                  memFullReset,
    output logic                  memReadPointerReset,
    output logic                  globalSetReset,
    output logic                  busy
);
    import bmrs_pkg::*;

    // ------------------------------------------------------------
    // Request gathering
    // ------------------------------------------------------------
    logic        gsrLive;
    logic        anyReq;
    logic        wrAffected_d;
    logic        wrAffected_q;
    bmrs_state_t state_q;
    logic        cntClear;
    logic        cntDone;
    logic [CNT_W-1:0] cntTarget;
    logic        fullRst_q;
    logic        rpRst_q;
    logic        gsr_q;

    // FIFO use forces the global set/reset on
    assign gsrLive = globalSetResetReq && (gsrEnable || fifoMode);
    assign anyReq  = fullResetReq || readPointerResetReq || gsrLive;
    // In FIFO mode, read-pointer reset alone leaves the write port free once wrAffected_q loads, one cycle after the request
    assign wrAffected_d = !fifoMode || fullResetReq || gsrLive;

    // ------------------------------------------------------------
    // Sequence control
    // ------------------------------------------------------------
    bmrs_quiet_counter #(
        .WIDTH (CNT_W)
    ) u_quiet (
        .clk    (clk),
        .resetn (resetn),
        .clear  (cntClear),
        .target (cntTarget),
        .done   (cntDone)
    );

    assign cntClear = (state_q == BMRS_RUN) || (state_q == BMRS_IN_RESET);
    // Settle count after release, quiet count before apply
    assign cntTarget = (state_q == BMRS_POST_QUIET) ? CNT_W'(`BMRS_SETTLE_CYCLES)
                                                    : CNT_W'(`BMRS_QUIET_CYCLES);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= BMRS_RUN;
        end else begin
            case (state_q)
                BMRS_RUN: begin
                    if (anyReq) begin
                        state_q <= BMRS_PRE_QUIET;
                    end
                end
                BMRS_PRE_QUIET: begin
                    if (cntDone) begin
                        state_q <= BMRS_IN_RESET;
                    end
                end
                BMRS_IN_RESET: begin
                    if (!anyReq) begin
                        state_q <= BMRS_POST_QUIET;
                    end
                end
                BMRS_POST_QUIET: begin
                    if (anyReq) begin
                        state_q <= BMRS_IN_RESET;
                    end else if (cntDone) begin
                        state_q <= BMRS_RUN;
                    end
                end
                default: begin
                    state_q <= BMRS_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrAffected_q <= 1'b1;
        end else if (state_q == BMRS_RUN && anyReq) begin
            wrAffected_q <= wrAffected_d;
        end else if (state_q != BMRS_RUN && wrAffected_d && anyReq) begin
            wrAffected_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Reset outputs, registered, asserted only while quiet
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fullRst_q <= 1'b0;
            rpRst_q   <= 1'b0;
            gsr_q     <= 1'b0;
        end else begin
            // Memory samples these asynchronously
            fullRst_q <= (state_q == BMRS_IN_RESET) && fullResetReq;
            rpRst_q   <= (state_q == BMRS_IN_RESET) && readPointerResetReq;
            gsr_q     <= (state_q == BMRS_IN_RESET) && gsrLive;
        end
    end

    assign memFullReset        = fullRst_q;
    assign memReadPointerReset = rpRst_q;
    assign globalSetReset      = gsr_q;

    // ------------------------------------------------------------
    // Enable gating
    // ------------------------------------------------------------
    logic quiet;
    assign quiet = (state_q != BMRS_RUN) || anyReq;

    assign memClockEnable    = userClockEnable && !quiet;
    assign memReadPortEnable = userReadPortEnable && !quiet;
    assign memWriteEnable    = userWriteEnable && !(quiet && wrAffected_q)
                               && !(anyReq && wrAffected_d);
    assign busy              = quiet;
endmodule : bmrs_sequencer
